// file: core/uswm_params.svh
// Overview of operation
// - In the shallowest suspend level, pin events, wake-on-LAN frames and address-repeat frames wake the device.
// - Entering the shallowest suspend level stops the clocks of the MAC and other internal modules.
// - In the second suspend level only pin events and link status changes wake the device.
// - In the third suspend level only pin assertion wakes the device and network events are ignored.
// - With no other level selected the third suspend level is used.
// - In the fourth suspend level pin events and good packets wake the device with near-full power.
// - A good packet is qualified by its own filter criteria, apart from the wake-frame criteria.
// - Software enables each network wake event to raise a USB remote wakeup.
// - With the host controller disabled a wake is signalled on the host wake output instead.
// - While suspended every general-purpose pin not taken by the external PHY can serve as a wake source.
// - Eleven pins are monitored with the internal PHY, fewer when the external PHY shares pins.
// - Eight independent wakeup frame filters may each raise a wake event.
`ifndef USWM_PARAMS_SVH
`define USWM_PARAMS_SVH
`define USWM_NUM_GPIO 11
`define USWM_NUM_GPIO_EXT 8
`define USWM_NUM_WUFF 8
`define USWM_SRC_GPIO 0
`define USWM_SRC_WOL 1
`define USWM_SRC_WUFF 2
`define USWM_SRC_LINK 3
`define USWM_SRC_GOOD 4
`define USWM_NUM_SRC 5
`endif

// file: core/uswm_pkg.sv
package uswm_pkg;
  typedef enum logic [1:0] {
    USWM_LVL_SHALLOW = 2'b00,
    USWM_LVL_LINKWAKE = 2'b01,
    USWM_LVL_PINONLY = 2'b10,
    USWM_LVL_GOODFRAME = 2'b11
  } uswm_level_t;
  typedef enum logic [1:0] {
    USWM_ST_RUN = 2'b00,
    USWM_ST_SUSP = 2'b01,
    USWM_ST_WAKE = 2'b10
  } uswm_state_t;
endpackage

// file: core/uswm_sync.sv
`timescale 1ns/1ns
// three-stage synchroniser; a change counts once stages two and three agree
module uswm_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      o_sync <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          o_sync[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // uswm_sync

// file: core/uswm_top.sv
`timescale 1ns/1ns
`include "uswm_params.svh"
module uswm_top (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // suspend control
  input wire logic I_SUSPEND_REQ,
  input wire logic I_LEVEL_SEL_VALID,
  input wire uswm_pkg::uswm_level_t I_LEVEL_SEL,
  input wire logic I_HOST_CTRL_DISABLED,
  input wire logic I_EXT_PHY_SEL,
  // wake enables
  input wire logic [`USWM_NUM_GPIO-1:0] I_GPIO_WAKE_EN,
  input wire logic [`USWM_NUM_GPIO-1:0] I_GPIO_WAKE_POL,
  input wire logic I_WOL_WAKE_EN,
  input wire logic [`USWM_NUM_WUFF-1:0] I_WUFF_WAKE_EN,
  input wire logic I_LINK_WAKE_EN,
  input wire logic I_GOOD_WAKE_EN,
  // wake source inputs
  input wire logic [`USWM_NUM_GPIO-1:0] I_GPIO,
  input wire logic I_LINK_UP,
  input wire logic I_WOL_MATCH,
  input wire logic [`USWM_NUM_WUFF-1:0] I_WUFF_MATCH,
  input wire logic I_RX_FRAME_DONE,
  input wire logic I_RX_FRAME_OK,
  input wire logic I_GOOD_FILTER_PASS,
  // status acknowledge
  input wire logic [`USWM_NUM_SRC-1:0] I_WAKE_STATUS_ACK,
  // outputs
  output logic O_MAC_CLK_EN,
  output logic O_SUSPENDED,
  output uswm_pkg::uswm_level_t O_ACTIVE_LEVEL,
  output logic O_REMOTE_WAKEUP,
  output logic O_HOST_WAKE_SIGNAL,
  output logic [`USWM_NUM_SRC-1:0] O_WAKE_STATUS,
  output logic [`USWM_NUM_WUFF-1:0] O_WUFF_STATUS
);
  import uswm_pkg::*;

  // pins and link state come from outside this clock domain
  logic [`USWM_NUM_GPIO-1:0] gpio_s;
  logic link_s;
  logic link_prev_q;
  logic [`USWM_NUM_GPIO-1:0] gpio_prev_q;

  uswm_sync #(.W(`USWM_NUM_GPIO + 1)) u_sync (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_async({I_LINK_UP, I_GPIO}),
    .o_sync({link_s, gpio_s})
  );

  uswm_level_t level_q;
  uswm_state_t state_q;
  uswm_state_t state_d;
  logic [`USWM_NUM_GPIO-1:0] gpio_avail;
  logic [`USWM_NUM_GPIO-1:0] gpio_hit;
  logic [`USWM_NUM_SRC-1:0] src_allow;
  logic [`USWM_NUM_SRC-1:0] src_hit;
  logic wake;

  // level choice is held; default is pin-only
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      level_q <= USWM_LVL_PINONLY;
    end else if (I_LEVEL_SEL_VALID && state_q == USWM_ST_RUN) begin
      level_q <= I_LEVEL_SEL;
    end
  end

  // external PHY takes the upper pins for its interface
  assign gpio_avail = I_EXT_PHY_SEL ? `USWM_NUM_GPIO'((1 << `USWM_NUM_GPIO_EXT) - 1)
                                    : '1;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      gpio_prev_q <= '0;
      link_prev_q <= 1'b0;
    end else begin
      gpio_prev_q <= gpio_s;
      link_prev_q <= link_s;
    end
  end

  // pin event: enabled pin reaches its active level from inactive
  assign gpio_hit = gpio_avail & I_GPIO_WAKE_EN
                  & (gpio_prev_q ^ I_GPIO_WAKE_POL)
                  & (gpio_s ^ ~I_GPIO_WAKE_POL);

  always_comb begin
    src_allow = '0;
    src_allow[`USWM_SRC_GPIO] = 1'b1;
    unique case (level_q)
      USWM_LVL_SHALLOW: begin
        src_allow[`USWM_SRC_WOL] = 1'b1;
        src_allow[`USWM_SRC_WUFF] = 1'b1;
      end
      USWM_LVL_LINKWAKE: begin
        src_allow[`USWM_SRC_LINK] = 1'b1;
      end
      USWM_LVL_PINONLY: begin
        src_allow[`USWM_SRC_GPIO] = 1'b1;
      end
      USWM_LVL_GOODFRAME: begin
        src_allow[`USWM_SRC_GOOD] = 1'b1;
      end
    endcase
  end

  // good packet uses its own filter pass, not the wake-frame matchers
  logic good_hit;
  assign good_hit = I_RX_FRAME_DONE & I_RX_FRAME_OK & I_GOOD_FILTER_PASS;

  logic [`USWM_NUM_WUFF-1:0] wuff_hit;
  assign wuff_hit = I_WUFF_MATCH & I_WUFF_WAKE_EN;

  always_comb begin
    src_hit = '0;
    src_hit[`USWM_SRC_GPIO] = |gpio_hit;
    src_hit[`USWM_SRC_WOL] = I_WOL_MATCH & I_WOL_WAKE_EN;
    src_hit[`USWM_SRC_WUFF] = |wuff_hit;
    src_hit[`USWM_SRC_LINK] = (link_s ^ link_prev_q) & I_LINK_WAKE_EN;
    src_hit[`USWM_SRC_GOOD] = good_hit & I_GOOD_WAKE_EN;
    src_hit = src_hit & src_allow;
  end

  // a source seen as the host resumes is stale, so resume takes priority
  assign wake = (state_q == USWM_ST_SUSP) && I_SUSPEND_REQ && (|src_hit);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      USWM_ST_RUN: begin
        if (I_SUSPEND_REQ) begin
          state_d = USWM_ST_SUSP;
        end
      end
      USWM_ST_SUSP: begin
        if (wake) begin
          state_d = USWM_ST_WAKE;
        end else if (!I_SUSPEND_REQ) begin
          state_d = USWM_ST_RUN;
        end
      end
      USWM_ST_WAKE: begin
        if (!I_SUSPEND_REQ) begin
          state_d = USWM_ST_RUN;
        end
      end
      default: begin
        state_d = USWM_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_q <= USWM_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // wake request held until the host ends suspend
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_REMOTE_WAKEUP <= 1'b0;
      O_HOST_WAKE_SIGNAL <= 1'b0;
    end else begin
      O_REMOTE_WAKEUP <= (state_d == USWM_ST_WAKE) && !I_HOST_CTRL_DISABLED;
      O_HOST_WAKE_SIGNAL <= (state_d == USWM_ST_WAKE) && I_HOST_CTRL_DISABLED;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_MAC_CLK_EN <= 1'b1;
      O_SUSPENDED <= 1'b0;
      O_ACTIVE_LEVEL <= USWM_LVL_PINONLY;
    end else begin
      O_SUSPENDED <= state_d != USWM_ST_RUN;
      O_ACTIVE_LEVEL <= level_q;
      // only the good-frame level keeps the MAC running in suspend
      O_MAC_CLK_EN <= (state_d == USWM_ST_RUN) || (level_q == USWM_LVL_GOODFRAME);
    end
  end

  // sticky sources; a set in the ack cycle wins
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_WAKE_STATUS <= '0;
      O_WUFF_STATUS <= '0;
    end else begin
      O_WAKE_STATUS <= (O_WAKE_STATUS & ~I_WAKE_STATUS_ACK)
                     | (wake ? src_hit : '0);
      O_WUFF_STATUS <= (O_WUFF_STATUS & ~{`USWM_NUM_WUFF{I_WAKE_STATUS_ACK[`USWM_SRC_WUFF]}})
                     | ((wake && src_hit[`USWM_SRC_WUFF]) ? wuff_hit : '0);
    end
  end
endmodule // uswm_top

// file: verification/uswm_host_model.sv
`timescale 1ns/1ns
module uswm_host_model #(
  parameter int DLY = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_sleep,
  input wire logic i_wake,
  output logic o_susp
);
  int cnt;
  // resume lags the wake so the wake output is seen standing
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn || !i_sleep) begin
      o_susp <= 1'b0;
      cnt <= 0;
    end else begin
      o_susp <= cnt < DLY;
      cnt <= cnt + int'(i_wake);
    end
  end
endmodule // uswm_host_model

// file: verification/uswm_checker.sv
`timescale 1ns/1ns
module uswm_checker (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_SUSPEND_REQ,
  input wire logic I_HOST_CTRL_DISABLED,
  input wire logic I_WOL_WAKE_EN,
  input wire logic I_WOL_MATCH,
  input wire logic [4:0] I_WAKE_STATUS_ACK,
  input wire logic O_MAC_CLK_EN,
  input wire logic O_SUSPENDED,
  input wire uswm_pkg::uswm_level_t O_ACTIVE_LEVEL,
  input wire logic O_REMOTE_WAKEUP,
  input wire logic O_HOST_WAKE_SIGNAL,
  input wire logic [4:0] O_WAKE_STATUS
);
  import uswm_pkg::*;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // still asleep: suspended with no wake standing yet
  wire on = I_SUSPEND_REQ && O_SUSPENDED && !O_REMOTE_WAKEUP && !O_HOST_WAKE_SIGNAL;
  wire wol = on && I_WOL_MATCH;
  AST_ENTER: assert property ($rose(I_SUSPEND_REQ) |=> O_SUSPENDED) else $error("no suspend");
  AST_MAC_STOP: assert property (
    O_SUSPENDED && O_ACTIVE_LEVEL != USWM_LVL_GOODFRAME |-> !O_MAC_CLK_EN) else $error("mac clk");
  AST_WOL_WAKE: assert property (
    wol && I_WOL_WAKE_EN && O_ACTIVE_LEVEL == USWM_LVL_SHALLOW
    |=> O_WAKE_STATUS[1] && (O_REMOTE_WAKEUP || O_HOST_WAKE_SIGNAL)) else $error("wol lost");
  AST_LINK_LVL: assert property (
    wol && O_ACTIVE_LEVEL == USWM_LVL_LINKWAKE |=> !$rose(O_WAKE_STATUS[1])) else $error("lvl1");
  AST_PIN_LVL: assert property (
    wol && O_ACTIVE_LEVEL == USWM_LVL_PINONLY |=> !$rose(O_WAKE_STATUS[1])) else $error("lvl2");
  AST_HOST_WAKE: assert property (
    $rose(O_HOST_WAKE_SIGNAL) |-> $past(I_HOST_CTRL_DISABLED)) else $error("host wake");
  AST_USB_WAKE: assert property (
    $rose(O_REMOTE_WAKEUP) |-> !$past(I_HOST_CTRL_DISABLED)) else $error("usb wake");
  AST_STICKY: assert property (
    O_WAKE_STATUS[1] && !I_WAKE_STATUS_ACK[1] |=> O_WAKE_STATUS[1]) else $error("sticky");
  AST_END: assert property ($fell(I_SUSPEND_REQ)
    |=> !O_REMOTE_WAKEUP && !O_HOST_WAKE_SIGNAL && !O_SUSPENDED) else $error("no resume");
  cover property (wol ##1 O_REMOTE_WAKEUP);
  cover property ($rose(O_HOST_WAKE_SIGNAL));
  cover property (O_WAKE_STATUS[1] && I_WAKE_STATUS_ACK[1]);
endmodule // uswm_checker
bind uswm_top uswm_checker u_chk (.I_CLK, .I_RSTN, .I_SUSPEND_REQ, .I_HOST_CTRL_DISABLED,
  .I_WOL_WAKE_EN, .I_WOL_MATCH, .I_WAKE_STATUS_ACK, .O_MAC_CLK_EN, .O_SUSPENDED,
  .O_ACTIVE_LEVEL, .O_REMOTE_WAKEUP, .O_HOST_WAKE_SIGNAL, .O_WAKE_STATUS);

// file: verification/uswm_tb_top.sv
`timescale 1ns/1ns
module uswm_tb_top;
  import uswm_pkg::*;
  logic clk = 0, rstn = 0, sleep = 0, req, lv = 0, hdis = 0, ext = 0, link = 0, wol = 0;
  logic fdone = 0, fpass = 0, wen = 1, mac_en, susp, rwk, hwk;
  logic [10:0] gen = 11'h7ff, gpio = '0;
  logic [7:0] wuff = '0, wufs;
  logic [4:0] ack = '0, wst;
  uswm_level_t lvl = USWM_LVL_SHALLOW, act;
  int n_errors = 0, n_tests = 0;
  always #4 clk = ~clk;
  uswm_host_model u_host (.i_clk(clk), .i_rstn(rstn), .i_sleep(sleep), .i_wake(rwk | hwk),
    .o_susp(req));
  uswm_top u_dut (.I_CLK(clk), .I_RSTN(rstn), .I_SUSPEND_REQ(req), .I_LEVEL_SEL_VALID(lv),
    .I_LEVEL_SEL(lvl), .I_HOST_CTRL_DISABLED(hdis), .I_EXT_PHY_SEL(ext), .I_GPIO_WAKE_EN(gen),
    .I_GPIO_WAKE_POL(11'h7ff), .I_WOL_WAKE_EN(wen), .I_WUFF_WAKE_EN({8{wen}}),
    .I_LINK_WAKE_EN(wen), .I_GOOD_WAKE_EN(wen), .I_GPIO(gpio), .I_LINK_UP(link), .I_WOL_MATCH(wol),
    .I_WUFF_MATCH(wuff), .I_RX_FRAME_DONE(fdone), .I_RX_FRAME_OK(fdone),
    .I_GOOD_FILTER_PASS(fpass), .I_WAKE_STATUS_ACK(ack), .O_MAC_CLK_EN(mac_en),
    .O_SUSPENDED(susp), .O_ACTIVE_LEVEL(act), .O_REMOTE_WAKEUP(rwk), .O_HOST_WAKE_SIGNAL(hwk),
    .O_WAKE_STATUS(wst), .O_WUFF_STATUS(wufs));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic go_sleep(input uswm_level_t l);
    lvl <= l;
    lv <= 1'b1;
    tick(1);
    lv <= 1'b0;
    sleep <= 1'b1;
    tick(3);
    @(negedge clk);
    chk("suspended", susp, 1);
    chk("mac_clk_en", mac_en, l == USWM_LVL_GOODFRAME);
    chk("active_level", act, l);
    tick(1);
  endtask
  task automatic wake_done(input logic [4:0] st);
    tick(1);
    sleep <= 1'b0;
    gpio <= '0;
    tick(8);
    @(negedge clk);
    chk("status", wst, st);
    tick(1);
    ack <= 5'h1f;
    tick(1);
    ack <= '0;
    tick(1);
    @(negedge clk);
    chk("status_ack", wst, 0);
    chk("awake", {susp, rwk, hwk}, 0);
    $display("test done");
    tick(1);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    tick(6000);
    n_errors++;
    stop_test;
  end
  initial begin
    tick(3);
    rstn <= 1'b1;
    tick(1);
    @(negedge clk);
    chk("level_reset", act, USWM_LVL_PINONLY);
    tick(1);
    // first frame fails the good filter, second passes
    for (int l = 0; l < 4; l++) begin
      go_sleep(uswm_level_t'(l));
      wol <= 1'b1;
      wuff <= 8'h80;
      link <= ~link;
      fdone <= 1'b1;
      tick(1);
      wol <= 1'b0;
      wuff <= '0;
      fpass <= 1'b1;
      @(negedge clk);
      chk("bad_frame", rwk, l == 0);
      tick(1);
      fdone <= 1'b0;
      fpass <= 1'b0;
      tick(5);
      @(negedge clk);
      chk("remote_wake", rwk, l != 2);
      chk("wuff_status", wufs, l == 0 ? 8'h80 : 8'h00);
      wake_done({l == 3, l == 1, l == 0, l == 0, 1'b0});
    end
    // network events left disabled by software must not wake
    wen <= 1'b0;
    go_sleep(USWM_LVL_SHALLOW);
    wol <= 1'b1;
    wuff <= 8'h01;
    tick(1);
    wol <= 1'b0;
    wuff <= '0;
    tick(3);
    @(negedge clk);
    chk("wol_disabled", rwk, 0);
    wake_done(5'h00);
    // pin 10 is shared with the external phy, so it must not wake
    hdis <= 1'b1;
    ext <= 1'b1;
    gen <= 11'h480;
    tick(1);
    go_sleep(USWM_LVL_PINONLY);
    gpio[10] <= 1'b1;
    tick(8);
    @(negedge clk);
    chk("gpio_ext", hwk | rwk, 0);
    tick(1);
    gpio[7] <= 1'b1;
    tick(6);
    @(negedge clk);
    chk("host_wake", {hwk, rwk}, 2'b10);
    wake_done(5'h01);
    stop_test;
  end
endmodule // uswm_tb_top
